//--- hdl/lfs_pkg.sv
package lfs_pkg;

    // Two-wire slave address, full eight-bit form
    localparam logic [7:0] ADDR_WRITE = 8'h58;
    localparam logic [7:0] ADDR_READ = 8'h59;
    localparam int DIR_BIT = 0;

    // Register indexes
    localparam logic [7:0] REG_BRIGHTNESS = 8'h00;
    localparam logic [7:0] REG_CONTROL = 8'h01;
    localparam logic [7:0] REG_FAULT_STATUS = 8'h02;
    localparam logic [7:0] REG_IDENT = 8'h03;

    // Reset values
    localparam logic [7:0] BRIGHTNESS_RST = 8'hFF;
    localparam logic [2:0] CONTROL_RST = 3'h0;
    // Arbitrary identification value
    localparam logic [7:0] IDENT_VALUE = 8'h5A;

    // Control register fields
    localparam int CTL_BL_ON = 0;
    localparam int CTL_BRT_SEL = 1;
    localparam int CTL_BRT_MODE = 2;
    localparam int CTL_WIDTH = 3;

    // Fault and status register fields
    localparam int STAT_FAULT = 0;
    localparam int STAT_THERMAL = 1;
    localparam int STAT_OVERCURRENT = 2;
    localparam int STAT_BL_ON = 3;
    localparam int STAT_ONE_OFF = 4;
    localparam int STAT_TWO_OFF = 5;

    // Channel count, fault timeout in dimming cycles, short cascade threshold and byte length
    localparam int NUM_CH = 8;
    localparam logic [2:0] FAULT_TIMEOUT = 3'd6;
    localparam logic [3:0] SHORT_ALL_OFF_COUNT = 4'd3;
    localparam logic [3:0] BITS_PER_BYTE = 4'd8;

    // Synchronised input bundle width
    localparam int SYNC_WIDTH = 24;

    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ACK_ADDR,
        BUS_CMD,
        BUS_ACK_CMD,
        BUS_WDATA,
        BUS_ACK_WDATA,
        BUS_ACK_RADDR,
        BUS_RDATA,
        BUS_HOLD
    } lfs_bus_state_t;

endpackage : lfs_pkg

//--- hdl/lfs_pin_sync.sv
`timescale 1ns/1ps
module lfs_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } lfs_sync_state_t;

    lfs_sync_state_t r_reg;
    lfs_sync_state_t r_next;

    always_comb
    begin
        r_next = r_reg;
        r_next.s1 = din;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        // A bit changes only once stages two and three agree
        for (int i = 0; i < WIDTH; i++)
        begin
            if (r_reg.s2[i] == r_reg.s3[i])
            begin
                r_next.q[i] = r_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign dout = r_reg.q;

endmodule : lfs_pin_sync

//--- hdl/lfs_supervisor.sv
`timescale 1ns/1ps
module lfs_supervisor (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic power_on,
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic dim_pwm,
    input wire logic [7:0] above_short,
    input wire logic [7:0] at_target,
    input wire logic over_voltage,
    input wire logic otp_lower,
    input wire logic otp_upper,
    input wire logic input_overcurrent,
    output logic [7:0] ch_drive,
    output logic [7:0] brightness
);

    typedef struct packed {
        lfs_pkg::lfs_bus_state_t st;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic [7:0] cmd;
        logic cmd_ok;
        logic [7:0] wdata;
        logic wpend;
        logic sda_oe;
        logic scl_d;
        logic sda_d;
        logic pwm_d;
        logic bl_d;
        logic [7:0] brt;
        logic [lfs_pkg::CTL_WIDTH-1:0] ctl;
        logic [7:0][2:0] cnt;
        logic [7:0] good;
        logic [7:0] dis;
        logic all_off;
        logic therm;
        logic [7:0] drive;
    } lfs_state_t;

    localparam lfs_state_t STATE_RST = '{
        st: lfs_pkg::BUS_IDLE,
        brt: lfs_pkg::BRIGHTNESS_RST,
        ctl: lfs_pkg::CONTROL_RST,
        default: '0
    };

    lfs_state_t r_reg;
    lfs_state_t r_next;

    logic [lfs_pkg::SYNC_WIDTH-1:0] syn;
    logic syn_en;
    logic syn_scl;
    logic syn_sda;
    logic syn_pwm;
    logic syn_ovp;
    logic syn_otp_lo;
    logic syn_otp_hi;
    logic syn_ocur;
    logic [7:0] syn_short;
    logic [7:0] syn_target;

    function automatic logic [3:0] lfs_count_ones(input logic [7:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            c = c + {3'h0, v[i]};
        end
        return c;
    endfunction : lfs_count_ones

    function automatic logic [7:0] lfs_read_reg(
        input logic [7:0] idx,
        input logic [7:0] brt,
        input logic [lfs_pkg::CTL_WIDTH-1:0] ctl,
        input logic [7:0] status
    );
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            lfs_pkg::REG_BRIGHTNESS: v = brt;
            lfs_pkg::REG_CONTROL: v = {{(8 - lfs_pkg::CTL_WIDTH){1'b0}}, ctl};
            lfs_pkg::REG_FAULT_STATUS: v = status;
            lfs_pkg::REG_IDENT: v = lfs_pkg::IDENT_VALUE;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : lfs_read_reg

    lfs_pin_sync #(
        .WIDTH(lfs_pkg::SYNC_WIDTH)
    ) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .din({power_on, scl, sda_i, dim_pwm, over_voltage, otp_lower, otp_upper,
            input_overcurrent, above_short, at_target}),
        .dout(syn)
    );

    assign {syn_en, syn_scl, syn_sda, syn_pwm, syn_ovp, syn_otp_lo, syn_otp_hi,
        syn_ocur, syn_short, syn_target} = syn;

    always_comb
    begin
        logic scl_rise;
        logic scl_fall;
        logic start_seen;
        logic stop_seen;
        logic dim_tick;
        logic bl_on;
        logic short_f;
        logic open_f;
        logic [3:0] off_count;
        logic [7:0] status;
        logic [7:0] rd;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_seen = 1'b0;
        stop_seen = 1'b0;
        dim_tick = 1'b0;
        bl_on = 1'b0;
        short_f = 1'b0;
        open_f = 1'b0;
        off_count = 4'h0;
        status = 8'h00;
        rd = 8'h00;
        r_next = r_reg;

        // Edge and bus condition detection on the synchronised pins
        scl_rise = syn_scl & ~r_reg.scl_d;
        scl_fall = ~syn_scl & r_reg.scl_d;
        start_seen = r_reg.scl_d & syn_scl & r_reg.sda_d & ~syn_sda;
        stop_seen = r_reg.scl_d & syn_scl & ~r_reg.sda_d & syn_sda;
        dim_tick = syn_pwm & ~r_reg.pwm_d;
        r_next.scl_d = syn_scl;
        r_next.sda_d = syn_sda;
        r_next.pwm_d = syn_pwm;

        // Fault and status view
        off_count = lfs_count_ones(r_reg.dis);
        status[lfs_pkg::STAT_TWO_OFF] = (off_count >= 4'd2);
        status[lfs_pkg::STAT_ONE_OFF] = (off_count == 4'd1);
        status[lfs_pkg::STAT_BL_ON] = |r_reg.drive;
        status[lfs_pkg::STAT_OVERCURRENT] = syn_ocur;
        status[lfs_pkg::STAT_THERMAL] = r_reg.therm;
        status[lfs_pkg::STAT_FAULT] = (off_count != 4'd0) | r_reg.therm | syn_ocur
            | r_reg.all_off;

        // Byte-wide two-wire slave
        if (start_seen)
        begin
            r_next.st = lfs_pkg::BUS_ADDR;
            r_next.bits = 4'h0;
            r_next.sda_oe = 1'b0;
        end
        else if (stop_seen)
        begin
            r_next.st = lfs_pkg::BUS_IDLE;
            r_next.sda_oe = 1'b0;
            r_next.cmd_ok = 1'b0;
            r_next.wpend = 1'b0;
            if (r_reg.wpend)
            begin
                // Write takes effect once the transaction completes
                case (r_reg.cmd)
                    lfs_pkg::REG_BRIGHTNESS: r_next.brt = r_reg.wdata;
                    lfs_pkg::REG_CONTROL:
                        r_next.ctl = r_reg.wdata[lfs_pkg::CTL_WIDTH-1:0];
                    default: r_next.brt = r_reg.brt;
                endcase
            end
        end
        else
        begin
            case (r_reg.st)
                lfs_pkg::BUS_IDLE:
                begin
                    r_next.sda_oe = 1'b0;
                end
                lfs_pkg::BUS_ADDR, lfs_pkg::BUS_CMD, lfs_pkg::BUS_WDATA:
                begin
                    if (scl_rise)
                    begin
                        r_next.shreg = {r_reg.shreg[6:0], syn_sda};
                        r_next.bits = r_reg.bits + 4'h1;
                    end
                    else if (scl_fall && r_reg.bits == lfs_pkg::BITS_PER_BYTE)
                    begin
                        r_next.bits = 4'h0;
                        r_next.sda_oe = 1'b1;
                        if (r_reg.st == lfs_pkg::BUS_ADDR)
                        begin
                            if (r_reg.shreg == lfs_pkg::ADDR_WRITE)
                            begin
                                r_next.st = lfs_pkg::BUS_ACK_ADDR;
                            end
                            else if (r_reg.shreg == lfs_pkg::ADDR_READ && r_reg.cmd_ok)
                            begin
                                r_next.st = lfs_pkg::BUS_ACK_RADDR;
                            end
                            else
                            begin
                                r_next.st = lfs_pkg::BUS_IDLE;
                                r_next.sda_oe = 1'b0;
                            end
                        end
                        else if (r_reg.st == lfs_pkg::BUS_CMD)
                        begin
                            r_next.cmd = r_reg.shreg;
                            r_next.cmd_ok = 1'b1;
                            r_next.st = lfs_pkg::BUS_ACK_CMD;
                        end
                        else
                        begin
                            r_next.wdata = r_reg.shreg;
                            r_next.st = lfs_pkg::BUS_ACK_WDATA;
                        end
                    end
                end
                lfs_pkg::BUS_ACK_ADDR:
                begin
                    if (scl_fall)
                    begin
                        r_next.sda_oe = 1'b0;
                        r_next.st = lfs_pkg::BUS_CMD;
                    end
                end
                lfs_pkg::BUS_ACK_CMD:
                begin
                    if (scl_fall)
                    begin
                        r_next.sda_oe = 1'b0;
                        r_next.st = lfs_pkg::BUS_WDATA;
                    end
                end
                lfs_pkg::BUS_ACK_WDATA:
                begin
                    if (scl_fall)
                    begin
                        r_next.sda_oe = 1'b0;
                        r_next.wpend = 1'b1;
                        r_next.st = lfs_pkg::BUS_HOLD;
                    end
                end
                lfs_pkg::BUS_ACK_RADDR:
                begin
                    if (scl_fall)
                    begin
                        rd = lfs_read_reg(r_reg.cmd, r_reg.brt, r_reg.ctl, status);
                        r_next.shreg = rd;
                        r_next.sda_oe = ~rd[7];
                        r_next.bits = 4'h1;
                        r_next.st = lfs_pkg::BUS_RDATA;
                    end
                end
                lfs_pkg::BUS_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (r_reg.bits == lfs_pkg::BITS_PER_BYTE)
                        begin
                            // Master owns the acknowledge after read data
                            r_next.sda_oe = 1'b0;
                            r_next.st = lfs_pkg::BUS_HOLD;
                        end
                        else
                        begin
                            r_next.sda_oe = ~r_reg.shreg[6];
                            r_next.shreg = {r_reg.shreg[6:0], 1'b0};
                            r_next.bits = r_reg.bits + 4'h1;
                        end
                    end
                end
                lfs_pkg::BUS_HOLD:
                begin
                    r_next.sda_oe = 1'b0;
                end
                default:
                begin
                    r_next.st = lfs_pkg::BUS_IDLE;
                    r_next.sda_oe = 1'b0;
                end
            endcase
        end

        // Channel fault supervision
        bl_on = r_reg.ctl[lfs_pkg::CTL_BL_ON];
        r_next.bl_d = bl_on;
        if (bl_on && !r_reg.bl_d)
        begin
            // Backlight re-enable clears every latched fault except a thermal trip still present
            r_next.dis = 8'h00;
            r_next.good = 8'h00;
            r_next.cnt = '0;
            r_next.all_off = 1'b0;
            // Trip still present at re-enable keeps the latch set
            r_next.therm = syn_otp_hi;
        end
        else
        begin
            if (syn_otp_hi)
            begin
                r_next.therm = 1'b1;
            end
            for (int i = 0; i < lfs_pkg::NUM_CH; i++)
            begin
                // Only a voltage above threshold counts as a short
                short_f = syn_short[i];
                open_f = ~syn_target[i] & (r_reg.good[i] | syn_ovp | syn_otp_lo);
                if (r_reg.drive[i] && syn_target[i])
                begin
                    r_next.good[i] = 1'b1;
                end
                if (!r_reg.drive[i] || syn_otp_hi || !(short_f || open_f))
                begin
                    r_next.cnt[i] = 3'h0;
                end
                else if (dim_tick)
                begin
                    if (r_reg.cnt[i] + 3'h1 == lfs_pkg::FAULT_TIMEOUT)
                    begin
                        r_next.dis[i] = 1'b1;
                        r_next.cnt[i] = 3'h0;
                        if (short_f && off_count >= lfs_pkg::SHORT_ALL_OFF_COUNT)
                        begin
                            r_next.all_off = 1'b1;
                        end
                    end
                    else
                    begin
                        r_next.cnt[i] = r_reg.cnt[i] + 3'h1;
                    end
                end
            end
        end
        if (bl_on && !r_next.therm && !r_next.all_off)
        begin
            r_next.drive = ~r_next.dis;
        end
        else
        begin
            r_next.drive = 8'h00;
        end

        // Power-on pin low holds everything at its reset state
        if (!syn_en)
        begin
            r_next = STATE_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            r_reg <= STATE_RST;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = r_reg.sda_oe;
    assign ch_drive = r_reg.drive;
    assign brightness = r_reg.brt;

endmodule : lfs_supervisor

//--- testbench/lfs_supervisor_props.sv
`timescale 1ns/1ps
module lfs_supervisor_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic power_on,
    input wire logic scl,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic dim_pwm,
    input wire logic otp_upper,
    input wire logic [7:0] ch_drive,
    input wire logic [7:0] brightness
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic [3:0] dim_cnt_reg;
    logic [3:0] idle_cnt_reg;
    logic dim_prev_reg;
    logic scl_prev_reg;
    logic [7:0] drive_prev_reg;

    // Dimming edges since the last change of channel drive
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dim_cnt_reg <= 4'h0;
            idle_cnt_reg <= 4'h0;
            dim_prev_reg <= 1'b0;
            scl_prev_reg <= 1'b1;
            drive_prev_reg <= 8'h00;
        end
        else
        begin
            dim_prev_reg <= dim_pwm;
            scl_prev_reg <= scl;
            drive_prev_reg <= ch_drive;
            if (ch_drive != drive_prev_reg)
                dim_cnt_reg <= 4'h0;
            else if (dim_pwm && !dim_prev_reg && dim_cnt_reg != 4'hF)
                dim_cnt_reg <= dim_cnt_reg + 4'h1;
            if (scl != scl_prev_reg)
                idle_cnt_reg <= 4'h0;
            else if (idle_cnt_reg != 4'hF)
                idle_cnt_reg <= idle_cnt_reg + 4'h1;
        end
    end

    sequence s_power_off;
        !power_on [*6];
    endsequence

    sequence s_single_drop;
        $changed(ch_drive) && ch_drive != 8'h00 && (ch_drive & ~$past(ch_drive)) == 8'h00;
    endsequence

    a_shutdown_off:
        assert property (s_power_off |-> ch_drive == 8'h00 && brightness == 8'hFF)
        else $error("channels driven or registers kept in shutdown");
    a_shutdown_mute:
        assert property (s_power_off |-> !sda_oe)
        else $error("data line driven in shutdown");
    a_upper_trip:
        assert property (otp_upper [*6] |-> ch_drive == 8'h00)
        else $error("channels driven with upper thermal trip");
    a_open_drain:
        assert property (sda_o == 1'b0)
        else $error("data line driven high");
    a_drive_bounded:
        assert property ($rose(sda_oe) |-> ##[1:80] !sda_oe)
        else $error("data line held too long");
    a_drive_in_frame:
        assert property (sda_oe |-> idle_cnt_reg < 4'hA)
        else $error("data line driven outside a transfer");
    a_dim_timeout:
        assert property (s_single_drop |-> dim_cnt_reg >= 4'h6)
        else $error("channel dropped before six dimming cycles");
    a_write_commit:
        assert property ($changed(brightness) |-> idle_cnt_reg >= 4'h8)
        else $error("brightness changed inside a transfer");
endmodule : lfs_supervisor_props

bind lfs_supervisor lfs_supervisor_props lfs_supervisor_props_i (
    .clk(clk), .rst_b(rst_b), .power_on(power_on), .scl(scl), .sda_o(sda_o),
    .sda_oe(sda_oe), .dim_pwm(dim_pwm), .otp_upper(otp_upper),
    .ch_drive(ch_drive), .brightness(brightness)
);

//--- testbench/lfs_host_model.sv
`timescale 1ns/1ps
module lfs_host_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_drv_low
);
    initial
    begin
        scl = 1'b1;
        sda_drv_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk

    // Data changes only while the clock is low
    // Rise no earlier than the device releases its ack
    task automatic put_bit(input logic b, output logic got);
        wait_clk(2);
        sda_drv_low <= ~b;
        wait_clk(3);
        scl <= 1'b1;
        wait_clk(3);
        got = sda_wire;
        scl <= 1'b0;
    endtask : put_bit

    // Ninth bit released: device ack slot, or host nack after read data
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            put_bit(tx[i], rx[i]);
        put_bit(1'b1, a);
        ack = ~a;
    endtask : xfer

    task automatic start_cond(input logic again);
        if (again)
        begin
            wait_clk(2);
            sda_drv_low <= 1'b0;
            wait_clk(3);
            scl <= 1'b1;
        end
        wait_clk(4);
        sda_drv_low <= 1'b1;
        wait_clk(4);
        scl <= 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_clk(2);
        sda_drv_low <= 1'b1;
        wait_clk(3);
        scl <= 1'b1;
        wait_clk(4);
        sda_drv_low <= 1'b0;
        wait_clk(8);
    endtask : stop_cond

    task automatic write_frame(input logic [7:0] addr, input logic [7:0] idx,
                               input logic [7:0] data, output logic ok);
        logic [7:0] r;
        logic a1;
        logic a2;
        logic a3;
        start_cond(1'b0);
        xfer(addr, r, a1);
        xfer(idx, r, a2);
        xfer(data, r, a3);
        stop_cond();
        ok = a1 & a2 & a3;
    endtask : write_frame

    task automatic read_reg(input logic [7:0] idx, output logic [7:0] data,
                            output logic ok);
        logic [7:0] r;
        logic a1;
        logic a2;
        logic a3;
        logic a4;
        start_cond(1'b0);
        xfer(lfs_pkg::ADDR_WRITE, r, a1);
        xfer(idx, r, a2);
        start_cond(1'b1);
        xfer(lfs_pkg::ADDR_READ, r, a3);
        xfer(8'hFF, data, a4);
        stop_cond();
        ok = a1 & a2 & a3;
    endtask : read_reg
endmodule : lfs_host_model

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`define CHECK(what, got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("unexpected %s: expected %h, seen %h", what, exp, got); \
        end \
    end

module tb_top;
    logic clk;
    logic rst_b;
    logic power_on;
    logic scl;
    logic sda_drv_low;
    logic sda_wire;
    logic sda_o;
    logic sda_oe;
    logic dim_pwm;
    logic [7:0] above_short;
    logic [7:0] at_target;
    logic over_voltage;
    logic otp_lower;
    logic otp_upper;
    logic input_overcurrent;
    logic [7:0] ch_drive;
    logic [7:0] brightness;
    logic ok;
    logic [7:0] rd;
    int error_cnt = 0;
    int num_checks = 0;

    // Open-drain data line with pull-up
    assign sda_wire = !(sda_drv_low || (sda_oe && !sda_o));

    lfs_supervisor lfs_supervisor_i (
        .clk(clk), .rst_b(rst_b), .power_on(power_on), .scl(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe(sda_oe), .dim_pwm(dim_pwm), .above_short(above_short),
        .at_target(at_target), .over_voltage(over_voltage), .otp_lower(otp_lower),
        .otp_upper(otp_upper), .input_overcurrent(input_overcurrent),
        .ch_drive(ch_drive), .brightness(brightness)
    );

    lfs_host_model lfs_host_model_i (
        .clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv_low(sda_drv_low)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic summarize();
        if (error_cnt == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize

    task automatic pulses(input int n);
        repeat (n)
        begin
            dim_pwm <= 1'b1;
            repeat (4) @(posedge clk);
            dim_pwm <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask : pulses

    task automatic read_check(input logic [7:0] idx, input logic [7:0] exp);
        lfs_host_model_i.read_reg(idx, rd, ok);
        `CHECK("read ack", ok, 1'b1)
        `CHECK("read data", rd, exp)
    endtask : read_check

    task automatic set_backlight(input logic on);
        lfs_host_model_i.write_frame(lfs_pkg::ADDR_WRITE, lfs_pkg::REG_CONTROL, {7'h00, on}, ok);
        repeat (8) @(posedge clk);
    endtask : set_backlight

    task automatic t_registers();
        read_check(lfs_pkg::REG_BRIGHTNESS, lfs_pkg::BRIGHTNESS_RST);
        lfs_host_model_i.write_frame(lfs_pkg::ADDR_WRITE, lfs_pkg::REG_BRIGHTNESS, 8'h3C, ok);
        `CHECK("write ack", ok, 1'b1)
        `CHECK("brightness", brightness, 8'h3C)
        read_check(lfs_pkg::REG_BRIGHTNESS, 8'h3C);
        read_check(lfs_pkg::REG_IDENT, lfs_pkg::IDENT_VALUE);
        lfs_host_model_i.write_frame(lfs_pkg::ADDR_WRITE, lfs_pkg::REG_FAULT_STATUS, 8'hFF, ok);
        read_check(lfs_pkg::REG_CONTROL, 8'h00);
        read_check(8'h07, 8'h00);
        lfs_host_model_i.write_frame(8'h5A, lfs_pkg::REG_BRIGHTNESS, 8'h11, ok);
        `CHECK("foreign address ack", ok, 1'b0)
        `CHECK("brightness kept", brightness, 8'h3C)
    endtask : t_registers

    task automatic t_channels_on();
        set_backlight(1'b1);
        pulses(8);
        `CHECK("drive clean", ch_drive, 8'hFF)
    endtask : t_channels_on

    task automatic t_short_timeout();
        above_short <= 8'h01;
        pulses(5);
        `CHECK("drive five edges", ch_drive, 8'hFF)
        above_short <= 8'h00;
        pulses(1);
        above_short <= 8'h01;
        pulses(5);
        `CHECK("drive after gap", ch_drive, 8'hFF)
        pulses(1);
        `CHECK("drive sixth edge", ch_drive, 8'hFE)
        read_check(lfs_pkg::REG_FAULT_STATUS, 8'h19);
    endtask : t_short_timeout

    task automatic t_short_cascade();
        above_short <= 8'h07;
        pulses(6);
        `CHECK("drive three off", ch_drive, 8'hF8)
        read_check(lfs_pkg::REG_FAULT_STATUS, 8'h29);
        above_short <= 8'h0F;
        pulses(6);
        `CHECK("drive cascade", ch_drive, 8'h00)
        above_short <= 8'h00;
        pulses(2);
        `CHECK("drive latched", ch_drive, 8'h00)
        set_backlight(1'b0);
        set_backlight(1'b1);
        `CHECK("drive restored", ch_drive, 8'hFF)
    endtask : t_short_cascade

    task automatic t_open_causes();
        for (int i = 0; i < 3; i++)
        begin
            // Later channels never reach target, so only their cause can fault them
            at_target <= (i == 0) ? 8'hFF : ~(8'h10 << i);
            set_backlight(1'b0);
            set_backlight(1'b1);
            at_target[4 + i] <= 1'b0;
            otp_lower <= (i == 1);
            over_voltage <= (i == 2);
            pulses(5);
            `CHECK("open five edges", ch_drive, 8'hFF)
            pulses(1);
            `CHECK("open timeout", ch_drive, ~(8'h10 << i))
        end
        at_target <= 8'hFF;
        otp_lower <= 1'b0;
        over_voltage <= 1'b0;
        set_backlight(1'b0);
        set_backlight(1'b1);
    endtask : t_open_causes

    task automatic t_upper_trip();
        otp_upper <= 1'b1;
        repeat (8) @(posedge clk);
        `CHECK("drive thermal", ch_drive, 8'h00)
        otp_upper <= 1'b0;
        input_overcurrent <= 1'b1;
        repeat (8) @(posedge clk);
        `CHECK("drive thermal latched", ch_drive, 8'h00)
        read_check(lfs_pkg::REG_FAULT_STATUS, 8'h07);
        input_overcurrent <= 1'b0;
        set_backlight(1'b0);
        set_backlight(1'b1);
        `CHECK("drive after thermal", ch_drive, 8'hFF)
    endtask : t_upper_trip

    task automatic t_shutdown();
        power_on <= 1'b0;
        repeat (8) @(posedge clk);
        `CHECK("drive shutdown", ch_drive, 8'h00)
        `CHECK("brightness shutdown", brightness, lfs_pkg::BRIGHTNESS_RST)
        lfs_host_model_i.write_frame(lfs_pkg::ADDR_WRITE, lfs_pkg::REG_BRIGHTNESS, 8'h22, ok);
        `CHECK("shutdown ack", ok, 1'b0)
        power_on <= 1'b1;
        repeat (8) @(posedge clk);
        read_check(lfs_pkg::REG_CONTROL, 8'h00);
    endtask : t_shutdown

    initial
    begin
        rst_b = 1'b0;
        power_on = 1'b1;
        dim_pwm = 1'b0;
        above_short = 8'h00;
        at_target = 8'hFF;
        over_voltage = 1'b0;
        otp_lower = 1'b0;
        otp_upper = 1'b0;
        input_overcurrent = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        t_registers();
        t_channels_on();
        t_short_timeout();
        t_short_cascade();
        t_open_causes();
        t_upper_trip();
        t_shutdown();
        summarize();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        error_cnt++;
        summarize();
    end
endmodule : tb_top
